// >>> common/dis_pkg.sv
// constants and carrier types of the internal supervision block
package dis_pkg;
    // timing
    localparam int CLK_PERIOD_NS = 8;
    localparam int LS_MIN_NS = 1000;
    localparam int LS_MAX_NS = 4000;
    localparam int STP_FILT_NS = 50;
    localparam int DT_MIN_NS = 200;
    localparam int DT_STEP_NS = 80;
    localparam logic [9:0] LS_MIN_CYC =
        10'((LS_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [9:0] LS_MAX_CYC = 10'(LS_MAX_NS / CLK_PERIOD_NS);
    localparam logic [2:0] STP_FILT_CYC =
        3'((STP_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] DT_MIN_CYC =
        8'((DT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] DT_STEP_CYC =
        8'((DT_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    // register offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_PCFG = 8'h04;
    localparam logic [7:0] REG_SCFG = 8'h08;
    localparam logic [7:0] REG_FLAG = 8'h0c;
    localparam logic [7:0] REG_STAT = 8'h10;
    localparam logic [7:0] REG_TIME = 8'h14;
    // field positions
    localparam int CTRL_ARM = 0;
    localparam int CFG_INJ = 8;
    localparam int F_PCL = 0;
    localparam int F_SCL = 1;
    localparam int F_STP = 2;
    localparam int F_GATE = 3;
    localparam int F_PPAR = 4;
    localparam int F_SPAR = 5;
    // reset values
    localparam logic [3:0] DT_RST = 4'h0;
    localparam logic [1:0] MODE_RST = 2'h0;
    localparam logic [5:0] FLAG_RST = 6'h00;
    // synchronised pin group, pwm in bit 0
    typedef struct packed {
        logic ls_sec;
        logic ls_pri;
        logic bias2_flt;
        logic bias1_flt;
        logic gate_lo;
        logic gate_hi;
        logic cpwm;
        logic pwm;
    } dis_pins_t;
endpackage

// >>> rtl/dis_top.sv
// internal supervision, shoot-through guard and gate monitoring
// Function
// RULE1 - two consecutive lifesign errors raise class B
// RULE2 - detecting side sets its comm-loss flag
// RULE3 - live link status bit beside sticky flags
// RULE4 - primary bias fault holds primary reset
// RULE5 - secondary bias fault: emergency off, reset
// RULE6 - configuration registers carry parity
// RULE7 - primary parity: reset, class B, off
// RULE8 - secondary parity: emergency off, reset
// RULE9 - counterpart on blocks own turn-on
// RULE10 - fixed minimum plus programmable dead time
// RULE11 - pwm on during inhibit: ignored, flagged
// RULE12 - conflicts under 50ns never flag
// RULE13 - guard always on, state readable
// RULE14 - turn-on timeout counter, overflow flags error
// RULE15 - turn-off timeout from hard point
// RULE16 - test modes suppress turn-on timeout only
// RULE17 - arm command sets both armed bits
// RULE18 - capture stores count, clears armed bit
// RULE19 - capture overflow stores ff
// RULE20 - timeout always, capture on request
// RULE21 - lifesign window times are parameters
// RULE22 - test modes disable upper monitoring
`timescale 1ns/1ps
module dis_top
    import dis_pkg::*;
(
    // clock and reset
    input wire logic core_clk_in,
    input wire logic reset_n_in,
    // ahb-lite slave
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    // pins
    input wire dis_pins_t pins_in,
    // driver controls
    output logic gate_on_out,
    output logic emergency_off_out,
    output logic primary_reset_ready_n_out,
    output logic secondary_reset_out,
    output logic class_b_fault_n_out,
    output logic on_monitor_en_out
);
    dis_pins_t s1, s2, s3, pf;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic acc;
    logic [31:0] next_rdata;
    logic [3:0] dt_cfg;
    logic dt_par;
    logic [1:0] mode_cfg;
    logic mode_par;
    logic [5:0] flags;
    logic [5:0] flag_set;
    logic [5:0] flag_clr;
    logic pri_par_err, sec_par_err, pri_rst, sec_rst, test_mode;
    logic [1:0] ls_lvl, ls_prev, ls_edge, ls_bad, ls_loss, ls_ok, ls_mask;
    logic link_ok;
    logic [7:0] dt_cnt;
    logic inhibit, pwm_prev, conf, stp_set;
    logic [2:0] conf_cnt;
    logic gon_q, on_start, off_start, run, is_on, hit, ovf, to_en;
    logic [7:0] tcnt;
    logic armed_on, armed_off, cap_act, arm_wr;
    logic [7:0] t_on, t_off;

    // pin synchronisers, change accepted once stages 2 and 3 agree
    always_ff @(posedge core_clk_in)
    begin
        if (!reset_n_in)
        begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            pf <= '0;
        end
        else
        begin
            s1 <= pins_in;
            s2 <= s1;
            s3 <= s2;
            pf <= (s2 ^ s3) & pf | ~(s2 ^ s3) & s2;
        end
    end

    // bus slave: zero wait states, always okay
    assign hreadyout_out = 1'b1;
    assign hresp_out = 1'b0;
    assign acc = hsel_in & htrans_in[1] & hready_in;

    always_ff @(posedge core_clk_in)
    begin
        if (!reset_n_in)
        begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
        end
        else if (hready_in)
        begin
            wr_pend <= acc & hwrite_in;
            wr_addr <= haddr_in[7:0];
        end
    end

    always_comb
    begin
        next_rdata = 32'h0000_0000;
        case (haddr_in[7:0])
            REG_PCFG: next_rdata = {23'h0, dt_par, 4'h0, dt_cfg};
            REG_SCFG: next_rdata = {23'h0, mode_par, 6'h0, mode_cfg};
            REG_FLAG: next_rdata = {26'h0, flags};
            REG_STAT: next_rdata = {24'h0, pf.bias2_flt, pf.bias1_flt,
                sec_rst, pri_rst, armed_off, armed_on, inhibit,
                link_ok}; // RULE3 RULE13
            REG_TIME: next_rdata = {16'h0, t_on, t_off};
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge core_clk_in)
    begin
        if (!reset_n_in)
            hrdata_out <= 32'h0000_0000;
        else if (acc && !hwrite_in)
            hrdata_out <= next_rdata;
    end

    // configuration with parity, inject bit stores it inverted
    always_ff @(posedge core_clk_in)
    begin
        if (!reset_n_in)
        begin
            dt_cfg <= DT_RST;
            dt_par <= 1'b0;
            mode_cfg <= MODE_RST;
            mode_par <= 1'b0;
        end
        else if (wr_pend && wr_addr == REG_PCFG)
        begin
            dt_cfg <= hwdata_in[3:0];
            dt_par <= ^hwdata_in[3:0] ^ hwdata_in[CFG_INJ]; // RULE6
        end
        else if (wr_pend && wr_addr == REG_SCFG)
        begin
            mode_cfg <= hwdata_in[1:0];
            mode_par <= ^hwdata_in[1:0] ^ hwdata_in[CFG_INJ]; // RULE6
        end
    end

    assign pri_par_err = (^dt_cfg) != dt_par; // RULE6
    assign sec_par_err = (^mode_cfg) != mode_par; // RULE6
    assign pri_rst = pf.bias1_flt | pri_par_err; // RULE4 RULE7
    assign sec_rst = pf.bias2_flt | sec_par_err; // RULE5 RULE8
    assign test_mode = |mode_cfg;
    assign arm_wr = wr_pend && wr_addr == REG_CTRL && hwdata_in[CTRL_ARM];

    // fault reactions
    always_ff @(posedge core_clk_in)
    begin
        if (!reset_n_in)
        begin
            emergency_off_out <= 1'b0;
            primary_reset_ready_n_out <= 1'b0;
            secondary_reset_out <= 1'b0;
            class_b_fault_n_out <= 1'b1;
            on_monitor_en_out <= 1'b1;
        end
        else
        begin
            emergency_off_out <= sec_rst | pri_par_err; // RULE5 RULE7 RULE8
            primary_reset_ready_n_out <= ~pri_rst; // RULE4 RULE7
            secondary_reset_out <= sec_rst; // RULE5 RULE8
            class_b_fault_n_out <= ~(flags[F_PCL] | flags[F_SCL]
                | pri_par_err); // RULE1 RULE7
            on_monitor_en_out <= ~test_mode; // RULE22
        end
    end

    // lifesign watchdogs: 0 watches secondary, 1 watches primary
    assign ls_lvl = {pf.ls_pri, pf.ls_sec};
    assign ls_mask = {pri_rst, sec_rst};
    assign link_ok = &ls_ok; // RULE3
    generate
        for (genvar i = 0; i < 2; i++)
        begin : g_ls
            logic [9:0] cnt;
            logic [1:0] miss;
            logic late;
            assign ls_edge[i] = (ls_lvl[i] != ls_prev[i]) & ~ls_mask[i];
            assign late = cnt >= LS_MAX_CYC - 10'h001; // RULE21
            assign ls_bad[i] = ls_edge[i] & (cnt < LS_MIN_CYC)
                | ~ls_edge[i] & late; // RULE21
            assign ls_loss[i] = ls_bad[i] & (miss == 2'h1); // RULE1
            assign ls_ok[i] = miss == 2'h0;
            always_ff @(posedge core_clk_in)
            begin
                if (!reset_n_in)
                begin
                    ls_prev[i] <= 1'b0;
                    cnt <= 10'h000;
                    miss <= 2'h0;
                end
                else
                begin
                    ls_prev[i] <= ls_lvl[i];
                    cnt <= (ls_edge[i] | late) ? 10'h000 : cnt + 10'h001;
                    if (ls_bad[i])
                        miss <= (miss == 2'h2) ? 2'h2 : miss + 2'h1;
                    else if (ls_edge[i])
                        miss <= 2'h0;
                end
            end
        end
    endgenerate

    // shoot-through guard, no disable
    assign inhibit = pf.cpwm | (dt_cnt != 8'h00); // RULE9 RULE13
    assign conf = pf.pwm & inhibit;
    assign stp_set = conf & (conf_cnt == STP_FILT_CYC - 3'h1); // RULE12

    always_ff @(posedge core_clk_in)
    begin
        if (!reset_n_in)
            dt_cnt <= 8'h00;
        else if (pf.cpwm)
            dt_cnt <= 8'(DT_MIN_CYC + {4'h0, dt_cfg} * DT_STEP_CYC); // RULE10
        else if (dt_cnt != 8'h00)
            dt_cnt <= dt_cnt - 8'h01;
    end

    always_ff @(posedge core_clk_in)
    begin
        if (!reset_n_in)
            conf_cnt <= 3'h0;
        else if (!conf)
            conf_cnt <= 3'h0;
        else if (conf_cnt != STP_FILT_CYC)
            conf_cnt <= conf_cnt + 3'h1; // RULE12
    end

    // turn-on needs a fresh pwm rise outside the inhibit interval
    always_ff @(posedge core_clk_in)
    begin
        if (!reset_n_in)
        begin
            pwm_prev <= 1'b0;
            gate_on_out <= 1'b0;
        end
        else
        begin
            pwm_prev <= pf.pwm;
            if (!pf.pwm || emergency_off_out)
                gate_on_out <= 1'b0;
            else if (!pwm_prev && !inhibit)
                gate_on_out <= 1'b1; // RULE9 RULE11
        end
    end

    // gate timeout and capture share one counter
    assign on_start = gate_on_out & ~gon_q;
    assign off_start = ~gate_on_out & gon_q;
    assign hit = is_on ? pf.gate_hi : pf.gate_lo;
    assign ovf = run & ~hit & (tcnt == 8'hff) & ~on_start & ~off_start;
    assign to_en = ~is_on | ~test_mode; // RULE16

    always_ff @(posedge core_clk_in)
    begin
        if (!reset_n_in)
        begin
            gon_q <= 1'b0;
            run <= 1'b0;
            is_on <= 1'b0;
            tcnt <= 8'h00;
        end
        else
        begin
            gon_q <= gate_on_out;
            if (on_start || off_start)
            begin
                tcnt <= 8'h00; // RULE14 RULE15 RULE20
                run <= 1'b1;
                is_on <= on_start;
            end
            else if (run && (hit || tcnt == 8'hff))
                run <= 1'b0;
            else if (run)
                tcnt <= tcnt + 8'h01;
        end
    end

    always_ff @(posedge core_clk_in)
    begin
        if (!reset_n_in)
        begin
            armed_on <= 1'b0;
            armed_off <= 1'b0;
            cap_act <= 1'b0;
            t_on <= 8'h00;
            t_off <= 8'h00;
        end
        else
        begin
            if (on_start || off_start)
            begin
                cap_act <= on_start ? armed_on : armed_off; // RULE20
                if (on_start && armed_on)
                    t_on <= 8'h00; // RULE18
                if (off_start && armed_off)
                    t_off <= 8'h00; // RULE18
            end
            else if (run && cap_act && (hit || ovf))
            begin
                cap_act <= 1'b0;
                if (is_on)
                begin
                    t_on <= ovf ? 8'hff : tcnt; // RULE18 RULE19
                    armed_on <= 1'b0;
                end
                else
                begin
                    t_off <= ovf ? 8'hff : tcnt; // RULE18 RULE19
                    armed_off <= 1'b0;
                end
            end
            if (arm_wr)
            begin
                armed_on <= 1'b1; // RULE17
                armed_off <= 1'b1;
            end
        end
    end

    // sticky flags, write one to clear, set wins
    assign flag_set = {sec_par_err, pri_par_err, ovf & to_en, stp_set,
        ls_loss[1], ls_loss[0]}; // RULE2 RULE11 RULE14 RULE15
    assign flag_clr = (wr_pend && wr_addr == REG_FLAG) ? hwdata_in[5:0]
        : 6'h00;

    always_ff @(posedge core_clk_in)
    begin
        if (!reset_n_in)
            flags <= FLAG_RST;
        else
            flags <= flags & ~flag_clr | flag_set;
    end

    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!reset_n_in);

    chk_two_errors: assert property ($rose(flags[F_PCL]) |-> // RULE1
        $past(ls_bad[0]) && $past(ls_ok[0]) == 1'b0)
        else $error("primary comm loss without two errors");
    chk_loss_flag: assert property (ls_loss[1] |=> flags[F_SCL] ##1 // RULE2
        !class_b_fault_n_out)
        else $error("secondary comm loss not flagged");
    chk_link_status: assert property (ls_bad[0] |=> !link_ok) // RULE3
        else $error("link status stayed good after error");
    chk_pri_bias: assert property (pf.bias1_flt |=> // RULE4
        !primary_reset_ready_n_out)
        else $error("primary not held on bias fault");
    chk_sec_bias: assert property (pf.bias2_flt |=> // RULE5
        emergency_off_out && secondary_reset_out)
        else $error("secondary bias fault not handled");
    chk_par_inject: assert property (wr_pend && wr_addr == REG_PCFG // RULE6
        && hwdata_in[CFG_INJ] |=> pri_par_err)
        else $error("corrupt parity not detected");
    chk_pri_parity: assert property (pri_par_err |=> // RULE7
        !class_b_fault_n_out && emergency_off_out
        && !primary_reset_ready_n_out)
        else $error("primary parity reaction missing");
    chk_sec_parity: assert property (sec_par_err |=> // RULE8
        emergency_off_out && secondary_reset_out)
        else $error("secondary parity reaction missing");
    chk_turnon_block: assert property ($rose(gate_on_out) |-> // RULE9
        $past(!inhibit))
        else $error("turn-on during inhibit");
    chk_dead_time: assert property ($fell(pf.cpwm) |-> // RULE10
        inhibit [*8])
        else $error("dead time shorter than minimum");
    chk_stp_filter: assert property ($rose(flags[F_STP]) |-> // RULE12
        $past(conf, 7) && $past(conf, 1))
        else $error("short conflict set shoot-through flag");
    chk_gate_timeout: assert property (ovf && to_en |=> // RULE14
        flags[F_GATE])
        else $error("timeout overflow not flagged");
    chk_mode_supp: assert property ($rose(flags[F_GATE]) |-> // RULE16
        $past(!(is_on && test_mode)))
        else $error("turn-on timeout not suppressed");
    chk_arm_both: assert property (arm_wr |=> // RULE17
        armed_on && armed_off)
        else $error("arm command did not arm both");
    chk_cap_sat: assert property (ovf && cap_act && is_on |=> // RULE19
        t_on == 8'hff && !armed_on)
        else $error("capture overflow not saturated");
endmodule // dis_top

// >>> tb/dis_partner.sv
// partner model: pwm sources, lifesign sources and gate response
`timescale 1ns/1ps
module dis_partner
    import dis_pkg::*;
(
    // clock and reset
    input wire logic core_clk_in,
    input wire logic reset_n_in,
    // bench controls
    input wire logic pwm_cmd_in,
    input wire logic cpwm_cmd_in,
    input wire logic [1:0] ls_en_in,
    input wire logic [1:0] bias_flt_in,
    input wire logic [7:0] gate_dly_in,
    // device side
    input wire logic gate_on_in,
    output dis_pins_t pins_out
);
    logic [7:0] ls_cnt;
    logic [1:0] ls_lvl;
    logic [7:0] gate_cnt;
    logic gate_q;
    // lifesigns toggle every 200 cycles, inside the window
    always_ff @(posedge core_clk_in)
    begin
        ls_cnt <= (!reset_n_in || ls_cnt == 8'hc7) ? 8'h00 : ls_cnt + 8'h01;
        if (!reset_n_in)
            ls_lvl <= 2'h0;
        else if (ls_cnt == 8'hc7)
            ls_lvl <= ls_lvl ^ ls_en_in;
    end
    // gate crosses gate_dly cycles after a switch, 0 = stuck
    always_ff @(posedge core_clk_in)
    begin
        gate_q <= gate_on_in;
        if (!reset_n_in || gate_q != gate_on_in)
            gate_cnt <= 8'h00;
        else if (gate_cnt != 8'hff)
            gate_cnt <= gate_cnt + 8'h01;
    end
    always_comb
    begin
        pins_out.pwm = pwm_cmd_in;
        pins_out.cpwm = cpwm_cmd_in;
        pins_out.gate_hi = gate_on_in && gate_dly_in != 8'h00
            && gate_cnt >= gate_dly_in;
        pins_out.gate_lo = !gate_on_in && gate_dly_in != 8'h00
            && gate_cnt >= gate_dly_in;
        pins_out.bias1_flt = bias_flt_in[0];
        pins_out.bias2_flt = bias_flt_in[1];
        pins_out.ls_pri = ls_lvl[0];
        pins_out.ls_sec = ls_lvl[1];
    end
endmodule // dis_partner

// >>> tb/tb_dis_top.sv
// self-checking bench of the internal supervision block
`timescale 1ns/1ps
module tb_dis_top
    import dis_pkg::*;
;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hready, hresp, gate_on, eoff, prst_n, srst, cb_n, mon_en;
    logic pwm = 1'b0;
    logic cpwm = 1'b0;
    logic [1:0] ls_en = 2'h3;
    logic [1:0] bias = 2'h0;
    logic [7:0] gate_dly = 8'h14;
    dis_pins_t pins;
    int bad_count = 0;
    int comparisons = 0;

    dis_top dis_top_inst (
        .core_clk_in(core_clk), .reset_n_in(rst_n), .hsel_in(hsel),
        .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
        .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hready),
        .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
        .pins_in(pins), .gate_on_out(gate_on), .emergency_off_out(eoff),
        .primary_reset_ready_n_out(prst_n), .secondary_reset_out(srst),
        .class_b_fault_n_out(cb_n), .on_monitor_en_out(mon_en));
    dis_partner dis_partner_inst (
        .core_clk_in(core_clk), .reset_n_in(rst_n), .pwm_cmd_in(pwm),
        .cpwm_cmd_in(cpwm), .ls_en_in(ls_en), .bias_flt_in(bias),
        .gate_dly_in(gate_dly), .gate_on_in(gate_on), .pins_out(pins));

    initial
    begin
        forever #4 core_clk = ~core_clk;
    end

    task end_sim;
        $display("checks %0d errors %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task chk(input string s, input logic [31:0] seen, input logic [31:0] e);
        comparisons++;
        if (seen !== e)
        begin
            bad_count++;
            $display("Error %s expected %h seen %h", s, e, seen);
        end
    endtask

    task chkb(input string s, input logic seen, input logic e);
        chk(s, {31'h0, seen}, {31'h0, e});
    endtask

    task hang(input string s);
        bad_count++;
        $display("Error %s wait ran out", s);
        end_sim;
    endtask

    task cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    task rdy;
        int n;
        n = 0;
        cyc(1);
        while (hready !== 1'b1)
        begin
            n++;
            if (n > 50)
                hang("hready");
            cyc(1);
        end
    endtask

    // one single word transfer, entered just after a rising edge
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        rdy;
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        rdy;
        r = hrdata;
        chkb("hresp", hresp, 1'b0);
    endtask

    task rd(input logic [7:0] a, output logic [31:0] v);
        bus(1'b0, a, 32'h0, v);
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] v;
        bus(1'b1, a, d, v);
    endtask

    task poll(input logic [7:0] a, input int b, input int lim);
        logic [31:0] v;
        v = 32'h0;
        for (int i = 0; i < lim && v[b] !== 1'b1; i++)
            rd(a, v);
        if (v[b] !== 1'b1)
            hang("poll");
    endtask

    task do_rst;
        rst_n <= 1'b0;
        pwm <= 1'b0;
        cpwm <= 1'b0;
        ls_en <= 2'h3;
        bias <= 2'h0;
        gate_dly <= 8'h14;
        cyc(8);
        rst_n <= 1'b1;
        cyc(1);
    endtask

    task t_life;
        logic [31:0] v;
        do_rst;
        rd(REG_FLAG, v);
        chk("flags", v, 32'(FLAG_RST));
        ls_en <= 2'h1;
        cyc(650);
        rd(REG_FLAG, v);
        chkb("one_err", v[F_PCL], 1'b0);
        rd(REG_STAT, v);
        chkb("link", v[0], 1'b0);
        poll(REG_FLAG, F_PCL, 600);
        chkb("cb_n", cb_n, 1'b0);
        rd(REG_FLAG, v);
        chkb("cl_sec", v[F_SCL], 1'b0);
        ls_en <= 2'h3;
        poll(REG_STAT, 0, 300);
        rd(REG_FLAG, v);
        chkb("sticky", v[F_PCL], 1'b1);
        wr(REG_FLAG, 32'h3f);
        rd(REG_FLAG, v);
        chkb("w1c", v[F_PCL], 1'b0);
    endtask

    // bias pin faults, then parity faults, primary side first
    task t_fault;
        for (int k = 0; k < 4; k++)
        begin
            do_rst;
            if (k < 2)
                bias <= 2'(k + 1);
            else
                wr(k == 2 ? REG_PCFG : REG_SCFG, 32'h100);
            cyc(8);
            if (k == 0 || k == 2)
            begin
                chkb("prst_n", prst_n, 1'b0);
                poll(REG_FLAG, k == 0 ? F_SCL : F_PPAR, 600);
                if (k == 2)
                    chkb("eoff_p", eoff, 1'b1);
            end
            else
            begin
                chkb("eoff", eoff, 1'b1);
                chkb("srst", srst, 1'b1);
                poll(REG_FLAG, F_PCL, 600);
                if (k == 3)
                    poll(REG_FLAG, F_SPAR, 5);
            end
            chkb("cb_n", cb_n, 1'b0);
        end
    endtask

    task t_stp;
        logic [31:0] v;
        do_rst;
        cpwm <= 1'b1;
        pwm <= 1'b1;
        cyc(3);
        pwm <= 1'b0;
        cyc(12);
        rd(REG_FLAG, v);
        chkb("glitch", v[F_STP], 1'b0);
        rd(REG_STAT, v);
        chkb("stp_st", v[1], 1'b1);
        pwm <= 1'b1;
        cyc(20);
        chkb("blocked", gate_on, 1'b0);
        rd(REG_FLAG, v);
        chkb("stp_err", v[F_STP], 1'b1);
        pwm <= 1'b0;
        for (int dt = 0; dt < 3; dt++)
        begin
            wr(REG_PCFG, 32'(dt));
            cpwm <= 1'b1;
            cyc(4);
            cpwm <= 1'b0;
            cyc(int'(DT_MIN_CYC) + int'(DT_STEP_CYC) * dt - 5);
            pwm <= 1'b1;
            cyc(12);
            chkb("dead", gate_on, 1'b0);
            pwm <= 1'b0;
            cyc(2);
            pwm <= 1'b1;
            cyc(8);
            chkb("on", gate_on, 1'b1);
            pwm <= 1'b0;
            cyc(8);
        end
    endtask

    task t_gate;
        logic [31:0] v;
        do_rst;
        chkb("mon_rst", mon_en, 1'b1);
        wr(REG_CTRL, 32'h1);
        chkb("prst_free", prst_n, 1'b1);
        chkb("cb_free", cb_n, 1'b1);
        chkb("srst_free", srst, 1'b0);
        rd(REG_STAT, v);
        chk("armed", 32'(v[3:2]), 32'h3);
        pwm <= 1'b1;
        cyc(60);
        rd(REG_STAT, v);
        chk("arm_on", 32'(v[3:2]), 32'h2);
        pwm <= 1'b0;
        cyc(60);
        rd(REG_TIME, v);
        chkb("t_on", v[15:8] inside {[8'h14:8'h20]}, 1'b1);
        chkb("t_off", v[7:0] inside {[8'h14:8'h20]}, 1'b1);
        rd(REG_STAT, v);
        chkb("arm_off", v[3], 1'b0);
        rd(REG_FLAG, v);
        chkb("gate_ok", v[F_GATE], 1'b0);
        gate_dly <= 8'h0;
        wr(REG_CTRL, 32'h1);
        pwm <= 1'b1;
        poll(REG_FLAG, F_GATE, 200);
        wr(REG_FLAG, 32'h3f);
        pwm <= 1'b0;
        poll(REG_FLAG, F_GATE, 200);
        rd(REG_TIME, v);
        chk("sat", v, 32'hffff);
        for (int m = 1; m < 3; m++)
        begin
            wr(REG_FLAG, 32'h3f);
            wr(REG_SCFG, 32'(m));
            cyc(2);
            chkb("mon_en", mon_en, 1'b0);
            pwm <= 1'b1;
            cyc(400);
            rd(REG_FLAG, v);
            chkb("on_supp", v[F_GATE], 1'b0);
            pwm <= 1'b0;
            poll(REG_FLAG, F_GATE, 200);
        end
    endtask

    initial
    begin
        t_life;
        t_fault;
        t_stp;
        t_gate;
        end_sim;
    end
endmodule // tb_dis_top
